// [rtl/tcm_pkg.sv]
package tcm_pkg;

	// ----------------------------------------------------------------
	// bus and register map
	// ----------------------------------------------------------------
	localparam int              ADDR_W      = 20;
	localparam int              DATA_W      = 16;
	localparam int              BYTE_W      = 8;
	localparam logic [19:0]     MODE_OFS    = 20'hF0190; // channel 0, +2 per channel
	localparam logic [19:0]     CH_STRIDE   = 20'h00002;
	localparam logic [19:0]     RELOAD_OFS  = 20'hF01A0;
	localparam logic [19:0]     COUNT_OFS   = 20'hF01A2;
	localparam logic [19:0]     CAPT_OFS    = 20'hF01A4;
	localparam logic [15:0]     MODE_RST    = 16'h0000;
	localparam logic [15:0]     MODE_WMASK  = 16'hDFCF; // bits 13, 5 and 4 read as zero
	localparam logic [15:0]     MODE_WMASK0 = 16'hD7CF; // channel 0 also drops bit 11
	localparam logic [15:0]     ZERO16      = 16'h0000;
	localparam logic [15:0]     ONE16       = 16'h0001;
	localparam logic [7:0]      ONE8        = 8'h01;
	localparam logic [7:0]      ZERO8       = 8'h00;

	// ----------------------------------------------------------------
	// mode register fields
	// ----------------------------------------------------------------
	localparam int              ROLE_BIT    = 11; // master select or byte split
	localparam int              STS_HI      = 10;
	localparam int              STS_LO      = 8;
	localparam int              EDGE_HI     = 7;
	localparam int              EDGE_LO     = 6;
	localparam int              MD_HI       = 3;
	localparam int              MD_LO       = 1;
	localparam int              MD0_BIT     = 0;

	typedef enum logic [2:0] {
		MODE_INTERVAL = 3'h0,
		MODE_CAPTURE  = 3'h2,
		MODE_EVENT    = 3'h3,
		MODE_ONE      = 3'h4,
		MODE_CAP_ONE  = 3'h6
	} tcm_mode_e;

	typedef enum logic [2:0] {
		TRIG_SW     = 3'h0,
		TRIG_PIN    = 3'h1,
		TRIG_BOTH   = 3'h2,
		TRIG_MASTER = 3'h4
	} tcm_trig_e;

	typedef enum logic [1:0] {
		ST_STOP = 2'h0,
		ST_WAIT = 2'h1,
		ST_RUN  = 2'h2
	} tcm_state_e;

endpackage : tcm_pkg

// [rtl/tcm_channel.sv]
// Strobed register access was left to the implementer.
`timescale 1ns/10ps
// What this block does
// (R1) channel 2 with master select set acts as master; clear means independent or slave
// (R2) only channel 2 has a writable master select bit
// (R3) channel 0 is always master; its bit 11 reads 0 and ignores writes
// (R4) software writes master select 0 for an independent channel
// (R5) channels 1 and 3: split bit 0 gives 16-bit, 1 gives 8-bit down-counting; the up-counting capture modes stay 16-bit
// (R6) trigger source 000 accepts software start only; undefined codes act the same
// (R7) trigger source 001: valid pin edge is start and capture trigger
// (R8) trigger source 010: the two pin edges give start and capture triggers
// (R9) trigger source 100: master interrupt input is the trigger
// (R10) edge code: 00 falling, 01 rising, 10 low width, 11 high width
// (R11) software uses edge code 10 for both edges unless source is 010
// (R12) mode 000 interval timer, counting down
// (R13) mode 010 capture, counting up
// (R14) mode 011 event counter, counting down, no start interrupt
// (R15) mode 100 one-count, counting down
// (R16) mode 110 capture plus one-count, counting up; undefined modes stop
// (R17) interval or capture: start bit 1 raises interrupt and toggles output at start
// (R18) one-count, start bit 0: start during counting ignored, no interrupt
// (R19) one-count, start bit 1: start during counting reloads, no interrupt
// (R20) capture plus one-count: no start interrupt, starts ignored while counting
// (R21) one-count: start bit never raises start interrupt or output change
// (R22) software leaves the mode register alone while the channel runs
// (R23) mode register resets to zero
module tcm_channel
	import tcm_pkg::*;
#(
	parameter int CHANNEL = 0
) (
	input  wire logic              clk_sys,
	input  wire logic              reset,
	input  wire logic              ce,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wdata,
	input  wire logic              wr,
	input  wire logic              rd,
	output logic      [DATA_W-1:0] rdata,
	input  wire logic              sw_start,
	input  wire logic              sw_stop,
	input  wire logic              timer_input_pin,
	input  wire logic              master_irq_in,
	output logic                   channel_interrupt,
	output logic                   timer_output_pin,
	output logic                   channel_enable_status,
	output logic                   master_role
);

	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	localparam logic [19:0] MODE_ADDR = MODE_OFS + CH_STRIDE * 20'(CHANNEL);
	localparam logic [15:0] WMASK     = (CHANNEL == 0) ? MODE_WMASK0 : MODE_WMASK;

	logic [15:0]  channel_mode_config;
	logic [15:0]  reload;
	logic [15:0]  count;
	logic [15:0]  capt;
	tcm_state_e   state;
	logic         pin_q;

	logic [15:0]  next_count;
	logic [15:0]  next_capt;
	tcm_state_e   next_state;
	logic         fire;
	logic         flip;

	// mode register; channel 0 bit 11 is masked off so it stays zero
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			channel_mode_config <= MODE_RST; // R23
		end else if (ce && wr && addr == MODE_ADDR) begin
			channel_mode_config <= wdata & WMASK; // R2 R3
		end
	end

	// reload value for the down-counting modes
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			reload <= ZERO16;
		end else if (ce && wr && addr == RELOAD_OFS) begin
			reload <= wdata;
		end
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rdata <= ZERO16;
		end else if (ce) begin
			if (!rd) begin
				rdata <= ZERO16;
			end else if (addr == MODE_ADDR) begin
				rdata <= channel_mode_config;
			end else if (addr == RELOAD_OFS) begin
				rdata <= reload;
			end else if (addr == COUNT_OFS) begin
				rdata <= count;
			end else if (addr == CAPT_OFS) begin
				rdata <= capt;
			end else begin
				rdata <= ZERO16; // unmapped reads as zero
			end
		end
	end

	// ----------------------------------------------------------------
	// field decode and trigger selection
	// ----------------------------------------------------------------
	tcm_mode_e    mode;
	tcm_trig_e    trig;
	logic [1:0]   edge_sel;
	logic         md0;
	logic         is_split;
	logic         rise;
	logic         fall;
	logic         start_edge;
	logic         cap_edge;
	logic         hw_start;
	logic         hw_cap;
	logic         st_trig;
	logic         sw_only;

	assign mode     = tcm_mode_e'(channel_mode_config[MD_HI:MD_LO]);
	assign trig     = tcm_trig_e'(channel_mode_config[STS_HI:STS_LO]);
	assign edge_sel = channel_mode_config[EDGE_HI:EDGE_LO];
	assign md0      = channel_mode_config[MD0_BIT];
	assign is_split = (CHANNEL == 1 || CHANNEL == 3) && channel_mode_config[ROLE_BIT]; // R5

	// pin is synchronous already; one flop gives the previous level for edges
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pin_q <= timer_input_pin; // track the pin so release brings no false edge
		end else if (ce) begin
			pin_q <= timer_input_pin;
		end
	end

	assign rise       = timer_input_pin & ~pin_q;
	assign fall       = ~timer_input_pin & pin_q;
	// low bit picks the start edge; width codes and source 010 capture on the other one
	assign start_edge = edge_sel[0] ? rise : fall; // R10
	assign cap_edge   = (edge_sel[1] || trig == TRIG_BOTH) ? (edge_sel[0] ? fall : rise) : start_edge; // R8 R10

	// undefined source codes fall back to software only, the safest reading
	always_comb begin
		hw_start = 1'b0;
		hw_cap   = 1'b0;
		sw_only  = 1'b0;
		unique case (trig)
			TRIG_SW: begin
				sw_only = 1'b1; // R6
			end
			TRIG_PIN, TRIG_BOTH: begin
				hw_start = start_edge; // R7 R8
				hw_cap   = cap_edge;
			end
			TRIG_MASTER: begin
				hw_start = master_irq_in; // R9
				hw_cap   = master_irq_in;
			end
			default: begin
				sw_only = 1'b1; // R6
			end
		endcase
	end

	assign st_trig = hw_start | sw_start;

	// ----------------------------------------------------------------
	// counting engine
	// ----------------------------------------------------------------
	logic [15:0]  dec;
	logic [15:0]  load;
	logic         at_zero;

	// in 8-bit split only the low byte counts down; the high byte is held
	assign dec     = is_split ? {count[15:8], count[7:0] - ONE8} : count - ONE16; // R5
	assign load    = is_split ? {count[15:8], reload[7:0]} : reload;
	assign at_zero = is_split ? (count[7:0] == ZERO8) : (count == ZERO16);

	always_comb begin
		next_state = state;
		next_count = count;
		next_capt  = capt;
		fire       = 1'b0;
		flip       = 1'b0;
		if (sw_stop) begin
			next_state = ST_STOP;
		end else begin
			unique case (mode)
				MODE_INTERVAL: begin
					if (sw_start) begin
						next_state = ST_RUN;
						next_count = load;
						fire       = md0; // R17
						flip       = md0;
					end else if (state == ST_RUN) begin
						if (at_zero) begin
							next_count = load;
							fire       = 1'b1;
							flip       = 1'b1;
						end else begin
							next_count = dec; // R12
						end
					end
				end
				MODE_CAPTURE: begin
					if (sw_start) begin
						next_state = ST_RUN;
						next_count = ZERO16;
						fire       = md0; // R17
						flip       = md0;
					end else if (state == ST_RUN) begin
						if (hw_cap) begin
							next_capt  = count;
							next_count = ZERO16;
							fire       = 1'b1;
						end else begin
							next_count = count + ONE16; // R13
						end
					end
				end
				MODE_EVENT: begin
					if (sw_start) begin
						next_state = ST_RUN;
						next_count = load; // R14
					end else if (state == ST_RUN && start_edge) begin
						if (at_zero) begin
							next_count = load;
							fire       = 1'b1;
							flip       = 1'b1;
						end else begin
							next_count = dec; // R14
						end
					end
				end
				MODE_ONE: begin
					// start never fires the interrupt or output here
					if (state == ST_STOP) begin
						if (sw_start) begin
							next_state = sw_only ? ST_RUN : ST_WAIT;
							next_count = load; // R21
						end
					end else if (state == ST_WAIT) begin
						if (st_trig) begin
							next_state = ST_RUN;
							next_count = load; // R21
						end
					end else if (st_trig && md0) begin
						next_count = load; // R19
					end else if (at_zero) begin
						next_state = ST_WAIT;
						fire       = 1'b1;
						flip       = 1'b1;
					end else begin
						next_count = dec; // R15 R18
					end
				end
				MODE_CAP_ONE: begin
					// start bit is not looked at: start triggers are ignored while counting
					if (state == ST_STOP) begin
						if (sw_start) begin
							next_state = sw_only ? ST_RUN : ST_WAIT;
							next_count = ZERO16; // R20
						end
					end else if (state == ST_WAIT) begin
						if (st_trig) begin
							next_state = ST_RUN;
							next_count = ZERO16;
						end
					end else if (hw_cap) begin
						next_state = ST_WAIT;
						next_capt  = count;
						fire       = 1'b1;
					end else begin
						next_count = count + ONE16; // R16 R20
					end
				end
				default: begin
					next_state = ST_STOP; // R16
				end
			endcase
		end
	end

	// run state
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state <= ST_STOP;
		end else if (ce) begin
			state <= next_state;
		end
	end

	// counter and capture value
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			count <= ZERO16;
			capt  <= ZERO16;
		end else if (ce) begin
			count <= next_count;
			capt  <= next_capt;
		end
	end

	// interrupt pulse, output toggle and enable status
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			channel_interrupt     <= 1'b0;
			timer_output_pin      <= 1'b0;
			channel_enable_status <= 1'b0;
		end else if (ce) begin
			channel_interrupt     <= fire;
			timer_output_pin      <= timer_output_pin ^ flip;
			channel_enable_status <= (next_state != ST_STOP);
		end
	end

	// master role: channel 0 always, channel 2 by its bit, others never
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			master_role <= (CHANNEL == 0);
		end else if (ce) begin
			master_role <= (CHANNEL == 0) || (CHANNEL == 2 && channel_mode_config[ROLE_BIT]); // R1 R2 R3
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	property p_ch0_bit11;
		@(posedge clk_sys) disable iff (reset)
		(CHANNEL != 2 && CHANNEL != 1 && CHANNEL != 3) |-> !channel_mode_config[ROLE_BIT];
	endproperty
	a_ch0_bit11: assert property (p_ch0_bit11) else $error("bit 11 set on a channel without it"); // R3

	property p_master;
		@(posedge clk_sys) disable iff (reset)
		ce |=> master_role == ((CHANNEL == 0) || (CHANNEL == 2 && $past(channel_mode_config[ROLE_BIT])));
	endproperty
	a_master: assert property (p_master) else $error("master role does not follow select bit"); // R1

	property p_start_irq;
		@(posedge clk_sys) disable iff (reset)
		(ce && !sw_stop && sw_start && md0 && (mode == MODE_INTERVAL || mode == MODE_CAPTURE))
		|=> channel_interrupt && (timer_output_pin != $past(timer_output_pin));
	endproperty
	a_start_irq: assert property (p_start_irq) else $error("no start interrupt with start bit set"); // R17

	property p_event_start;
		@(posedge clk_sys) disable iff (reset)
		(ce && !sw_stop && sw_start && mode == MODE_EVENT) |=> !channel_interrupt && count == $past(load);
	endproperty
	a_event_start: assert property (p_event_start) else $error("event counter start misbehaved"); // R14

	property p_one_ignore;
		@(posedge clk_sys) disable iff (reset)
		(ce && !sw_stop && mode == MODE_ONE && state == ST_RUN && st_trig && !md0 && !at_zero)
		|=> count == $past(dec) && !channel_interrupt;
	endproperty
	a_one_ignore: assert property (p_one_ignore) else $error("one-count start not ignored"); // R18

	property p_one_retrig;
		@(posedge clk_sys) disable iff (reset)
		(ce && !sw_stop && mode == MODE_ONE && state == ST_RUN && st_trig && md0)
		|=> count == $past(load) && !channel_interrupt && state == ST_RUN;
	endproperty
	a_one_retrig: assert property (p_one_retrig) else $error("one-count restart wrong"); // R19

	property p_interval_down;
		@(posedge clk_sys) disable iff (reset)
		(ce && !sw_stop && !sw_start && mode == MODE_INTERVAL && state == ST_RUN && !at_zero)
		|=> count == $past(dec);
	endproperty
	a_interval_down: assert property (p_interval_down) else $error("interval timer not counting down"); // R12

	property p_capture_up;
		@(posedge clk_sys) disable iff (reset)
		(ce && !sw_stop && !sw_start && mode == MODE_CAPTURE && state == ST_RUN && !hw_cap)
		|=> count == $past(count) + ONE16;
	endproperty
	a_capture_up: assert property (p_capture_up) else $error("capture mode not counting up"); // R13

	property p_capone_start;
		@(posedge clk_sys) disable iff (reset)
		(ce && !sw_stop && mode == MODE_CAP_ONE && state != ST_RUN) |=> !channel_interrupt;
	endproperty
	a_capone_start: assert property (p_capone_start) else $error("start interrupt in capture one-count"); // R20

	property p_reset_mode;
		@(posedge clk_sys)
		reset |=> channel_mode_config == MODE_RST && !channel_enable_status;
	endproperty
	a_reset_mode: assert property (p_reset_mode) else $error("mode register not cleared by reset"); // R23

endmodule : tcm_channel

// [bench/tcm_far_side.sv]
`timescale 1ns/10ps
// ----------------------------------------------------------------
// far side: timer input pin and the master channel's interrupt
// ----------------------------------------------------------------
module tcm_far_side (
	input  wire logic clk_sys,
	input  wire logic pin_req,
	input  wire logic master_irq,
	output logic      timer_input_pin,
	output logic      master_irq_in
);
	// pin is synchronous to clk_sys, so it only moves after an edge
	always_ff @(posedge clk_sys) begin
		timer_input_pin <= pin_req;
	end
	// slave trigger is the master's interrupt pulse, passed on as is
	assign master_irq_in = master_irq;
endmodule : tcm_far_side

// [bench/timer_channel_mode_control_test.sv]
`timescale 1ns/10ps
module timer_channel_mode_control_test;
	import tcm_pkg::*;
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin n_fail++; $display("BAD %s exp %0h got %0h", n, e, s); end end
	localparam logic [19:0] MODE2 = 20'hF0194;
	logic              clk_sys  = 1'b0;
	logic              reset    = 1'b1;
	logic [ADDR_W-1:0] addr     = '0;
	logic [DATA_W-1:0] wdata    = '0;
	logic              wr       = 1'b0;
	logic              rd       = 1'b0;
	logic              sel      = 1'b0;
	logic              sw_start = 1'b0;
	logic              sw_stop  = 1'b0;
	logic              pin_req  = 1'b0;
	logic [DATA_W-1:0] rdata [2];
	logic              irq [2];
	logic              tout [2];
	logic              en [2];
	logic              mrole [2];
	logic              tin;
	logic              mirq;
	logic              hit;
	logic              o;
	logic [15:0]       v;
	logic [15:0]       cap [2];
	int                checked = 0;
	int                n_fail  = 0;
	int                c;
	int                t0;
	logic [15:0]       md [7]  = '{16'h0000, 16'h0001, 16'h0004, 16'h0005, 16'h0006, 16'h0008, 16'h0009};
	logic              ex [7]  = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
	logic [15:0]       cfg [4] = '{16'h02CC, 16'h018C, 16'h020C, 16'h024C};
	logic              idl [4] = '{1'b0, 1'b1, 1'b1, 1'b0};

	initial begin
		forever #20 clk_sys = ~clk_sys;
	end

	// channel 0 is the fixed master, channel 2 the one under test
	tcm_channel #(.CHANNEL(0)) dut0_u (.clk_sys(clk_sys), .reset(reset), .ce(1'b1), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd & !sel), .rdata(rdata[0]), .sw_start(sw_start), .sw_stop(sw_stop),
		.timer_input_pin(tin), .master_irq_in(1'b0), .channel_interrupt(irq[0]), .timer_output_pin(tout[0]),
		.channel_enable_status(en[0]), .master_role(mrole[0]));
	tcm_channel #(.CHANNEL(2)) dut_u (.clk_sys(clk_sys), .reset(reset), .ce(1'b1), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd & sel), .rdata(rdata[1]), .sw_start(sw_start), .sw_stop(sw_stop),
		.timer_input_pin(tin), .master_irq_in(mirq), .channel_interrupt(irq[1]), .timer_output_pin(tout[1]),
		.channel_enable_status(en[1]), .master_role(mrole[1]));
	tcm_far_side far_u (.clk_sys(clk_sys), .pin_req(pin_req), .master_irq(irq[0]), .timer_input_pin(tin),
		.master_irq_in(mirq));

	// ----------------------------------------------------------------
	// bus and trigger tasks
	// ----------------------------------------------------------------
	task automatic bus_wr(input logic [19:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask : bus_wr

	task automatic bus_rd(input logic s, input logic [19:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		sel <= s;
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1 d = rdata[s];
	endtask : bus_rd

	// one-cycle start (stp=0) or stop (stp=1) pulse
	task automatic trig(input logic stp);
		@(posedge clk_sys);
		sw_start <= !stp;
		sw_stop <= stp;
		@(posedge clk_sys);
		sw_start <= 1'b0;
		sw_stop <= 1'b0;
	endtask : trig

	// edges until an interrupt is seen; bounded so a dead channel cannot hang
	task automatic wait_irq(input int i, output int n);
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (irq[i] !== 1'b1 && n < 60);
	endtask : wait_irq

	task automatic end_sim;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_sim

	// watchdog: the whole sequence needs well under a thousand cycles
	initial begin
		repeat (3000) @(posedge clk_sys);
		n_fail++;
		end_sim();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clk_sys);
		reset <= 1'b0;
		bus_rd(1'b0, MODE_OFS, v);
		`CHK("mode0_rst", 16'h0000, v)
		bus_rd(1'b1, MODE2, v);
		`CHK("mode2_rst", 16'h0000, v)
		`CHK("role0", 1'b1, mrole[0])
		`CHK("role2", 1'b0, mrole[1])
		bus_wr(MODE_OFS, 16'hFFFF);
		bus_wr(MODE2, 16'hFFFF);
		bus_rd(1'b0, MODE_OFS, v);
		`CHK("mode0_rw", 16'hD7CF, v)
		bus_rd(1'b1, MODE2, v);
		`CHK("mode2_rw", 16'hDFCF, v)
		`CHK("role0_set", 1'b1, mrole[0])
		`CHK("role2_set", 1'b1, mrole[1])
		bus_wr(MODE_OFS, 16'h0000);
		bus_wr(MODE2, 16'h0000);
		bus_rd(1'b0, 20'hF0198, v);
		`CHK("unmapped", 16'h0000, v)
		`CHK("role2_clr", 1'b0, mrole[1])
		// start interrupt and output per mode except capture plus one-count, stopped before each rewrite
		bus_wr(RELOAD_OFS, 16'h0002);
		foreach (md[k]) begin
			bus_wr(MODE2, md[k]);
			o = tout[1];
			trig(1'b0);
			#1 `CHK("start_irq", ex[k], irq[1])
			`CHK("start_out", o ^ ex[k], tout[1])
			`CHK("enable", 1'b1, en[1])
			trig(1'b1);
		end
		// interval period with reload 2 counting down
		bus_wr(MODE2, 16'h0001);
		trig(1'b0);
		wait_irq(1, c);
		wait_irq(1, c);
		`CHK("period", 3, c)
		trig(1'b1);
		// one-count: restart during counting only with start bit set
		bus_wr(RELOAD_OFS, 16'h0004);
		for (int b = 0; b < 2; b++) begin
			bus_wr(MODE2, {15'h0004, b[0]});
			trig(1'b0);
			wait_irq(1, t0);
			trig(1'b1);
			trig(1'b0);
			trig(1'b0);
			wait_irq(1, c);
			`CHK("one_retrig", b ? t0 : t0 - 2, c)
			trig(1'b1);
		end
		// capture plus one-count: pin edges and width measurement
		foreach (cfg[k]) begin
			pin_req <= idl[k];
			bus_wr(MODE2, cfg[k]);
			trig(1'b0);
			for (int w = 0; w < 2; w++) begin
				@(posedge clk_sys);
				pin_req <= !idl[k];
				hit = 1'b0;
				repeat (3 + 3 * w) begin
					@(posedge clk_sys);
					hit |= irq[1];
				end
				`CHK("no_start_irq", 1'b0, hit)
				pin_req <= idl[k];
				wait_irq(1, c);
				`CHK("capture_irq", 1'b1, irq[1])
				bus_rd(1'b1, CAPT_OFS, cap[w]);
			end
			`CHK("width", 16'h0003, cap[1] - cap[0])
			trig(1'b1);
		end
		// source 000: pin edges must not capture
		pin_req <= 1'b0;
		bus_wr(MODE2, 16'h008C);
		trig(1'b0);
		hit = 1'b0;
		repeat (10) begin
			@(posedge clk_sys);
			pin_req <= !pin_req;
			hit |= irq[1];
		end
		`CHK("sw_only", 1'b0, hit)
		trig(1'b1);
		// event counter: ten rising pin edges against a reload of 4 give two interrupts
		pin_req <= 1'b0;
		bus_wr(MODE2, 16'h0146);
		trig(1'b0);
		c = 0;
		for (int i = 0; i < 24; i++) begin
			@(posedge clk_sys);
			if (i < 20) begin
				pin_req <= !pin_req;
			end
			if (irq[1] === 1'b1) begin
				c++;
			end
		end
		`CHK("event_irqs", 2, c)
		trig(1'b1);
		// slave one-count started by the master's start interrupt
		bus_wr(MODE_OFS, 16'h0001);
		bus_wr(MODE2, 16'h0408);
		trig(1'b0);
		wait_irq(1, c);
		`CHK("slave_start", t0 + 1, c)
		trig(1'b1);
		end_sim();
	end
endmodule : timer_channel_mode_control_test
